// File: src/cis_core.sv
/*
 Executes the tail group of the instruction set and the operand fetch
 of the listed addressing modes; other opcodes retire as no-ops.
 Assumes memory answers a read combinationally in the same cycle and
 takes a write at the clock edge; one access per cycle.
*/
`include "cis_defs.svh"
module cis_core
    import cis_pkg::*;
(
    input wire logic mclk, // Core clock, 100 MHz
    input wire logic arst_n, // Asynchronous reset, active low
    input wire logic [7:0] mem_rdata, // Read data for this cycle
    output cis_mem_req_t mem_req, // Memory access request
    output cis_regs_t regs, // Programmer-visible registers
    output logic retire // Instruction completed
);
    cis_state_t st_q, st_d;
    cis_dec_t dec_q, dec_d;
    logic [15:0] pc_q, pc_d, hx_q, hx_d, sp_q, sp_d, ea;
    logic [7:0] a_q, a_d, flg_q, flg_d, b1_q, b1_d, b2_q, b2_d;
    logic [7:0] tmp_q, tmp_d, rel;
    logic [2:0] cnt_q, cnt_d;
    logic retire_q, retire_d, bitv;

    function automatic cis_dec_t decode(input logic [7:0] op,
                                        input logic pre);
        cis_dec_t d;
        d = '{kind: K_NOP, mode: M_NONE, nbytes: 2'h0, sub: op[3:0]};
        if (pre) begin
            unique case (op)
                `CIS_OP_ZMEM_I8: d = '{K_ZMEM, M_STK8, 2'h1, op[3:0]};
                `CIS_OP_LD_S8: d = '{K_LOAD, M_STK8, 2'h1, op[3:0]};
                `CIS_OP_LD_S16: d = '{K_LOAD, M_STK16, 2'h2, op[3:0]};
                default: d.kind = K_NOP;
            endcase
        end else if (op[7:4] == 4'h0) begin
            d = '{K_BITBR, M_SHORT, 2'h2, op[3:0]};
        end else begin
            unique case (op)
                `CIS_OP_JUMP: d = '{K_JUMP, M_NONE, 2'h1, op[3:0]};
                `CIS_OP_ZMEM_SH: d = '{K_ZMEM, M_SHORT, 2'h1, op[3:0]};
                `CIS_OP_ZACC: d.kind = K_ZACC;
                `CIS_OP_ZIDX: d.kind = K_ZIDX;
                `CIS_OP_ZMEM_I8: d = '{K_ZMEM, M_IDX8, 2'h1, op[3:0]};
                `CIS_OP_ZMEM_IX: d = '{K_ZMEM, M_IDX, 2'h0, op[3:0]};
                `CIS_OP_MV_SH2SH: d = '{K_MOVE, M_SH2SH, 2'h2, op[3:0]};
                `CIS_OP_MV_SH2PI: d = '{K_MOVE, M_SH2PI, 2'h1, op[3:0]};
                `CIS_OP_MV_LIT: d = '{K_MOVE, M_LIT2SH, 2'h2, op[3:0]};
                `CIS_OP_MV_PI2SH: d = '{K_MOVE, M_PI2SH, 2'h1, op[3:0]};
                `CIS_OP_CB_PI8: d = '{K_CMPBR, M_PI8, 2'h2, op[3:0]};
                `CIS_OP_CB_PI: d = '{K_CMPBR, M_PI, 2'h1, op[3:0]};
                `CIS_OP_TRAP: d.kind = K_TRAP;
                `CIS_OP_FLGLD: d.kind = K_FLGLD;
                `CIS_OP_FLGRD: d.kind = K_FLGRD;
                `CIS_OP_HX2S: d.kind = K_HX2S;
                `CIS_OP_S2HX: d.kind = K_S2HX;
                `CIS_OP_A2X: d.kind = K_A2X;
                `CIS_OP_X2A: d.kind = K_X2A;
                `CIS_OP_LD_LONG: d = '{K_LOAD, M_LONG, 2'h2, op[3:0]};
                `CIS_OP_LD_I16: d = '{K_LOAD, M_IDX16, 2'h2, op[3:0]};
                `CIS_OP_LD_I8: d = '{K_LOAD, M_IDX8, 2'h1, op[3:0]};
                `CIS_OP_LD_IX: d = '{K_LOAD, M_IDX, 2'h0, op[3:0]};
                default: d.kind = K_NOP;
            endcase
        end
        return d;
    endfunction

    // Subtracting zero leaves the value, so N and Z come from it directly
    function automatic logic [7:0] nz(input logic [7:0] f,
                                      input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[`CIS_FLG_V] = 1'b0;
        r[`CIS_FLG_N] = v[7];
        r[`CIS_FLG_Z] = (v == 8'h00);
        return r;
    endfunction

    cis_ea u_ea (
        .mode(dec_q.mode),
        .b1(b1_q),
        .b2(b2_q),
        .hx(hx_q),
        .sp(sp_q),
        .ea(ea)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        dec_d = dec_q;
        pc_d = pc_q;
        hx_d = hx_q;
        sp_d = sp_q;
        a_d = a_q;
        flg_d = flg_q;
        b1_d = b1_q;
        b2_d = b2_q;
        tmp_d = tmp_q;
        cnt_d = cnt_q;
        mem_req = '0;
        rel = (dec_q.mode == M_PI8 || dec_q.kind == K_BITBR) ? b2_q : b1_q;
        bitv = mem_rdata[dec_q.sub[3:1]];
        unique case (st_q)
            S_FETCH, S_PRE: begin
                mem_req.rd = 1'b1;
                mem_req.addr = pc_q;
                pc_d = pc_q + 16'h0001;
                cnt_d = 3'h0;
                if (st_q == S_FETCH && mem_rdata == `CIS_OP_PREFIX) begin
                    st_d = S_PRE;
                end else begin
                    dec_d = decode(mem_rdata, st_q == S_PRE);
                    st_d = (dec_d.nbytes == 2'h0) ? S_EXEC : S_OPND;
                end
            end
            S_OPND: begin
                // High byte arrives first for long and word offsets
                mem_req.rd = 1'b1;
                mem_req.addr = pc_q;
                pc_d = pc_q + 16'h0001;
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == 3'h0) begin
                    b1_d = mem_rdata;
                end else begin
                    b2_d = mem_rdata;
                end
                if (cnt_q[1:0] + 2'h1 == dec_q.nbytes) begin
                    st_d = S_EXEC;
                end
            end
            S_EXEC: begin
                st_d = S_FETCH;
                mem_req.addr = ea;
                unique case (dec_q.kind)
                    K_FLGLD: flg_d = a_q | `CIS_FLG_ONES;
                    K_FLGRD: a_d = flg_q;
                    K_A2X: hx_d[7:0] = a_q;
                    K_X2A: a_d = hx_q[7:0];
                    K_S2HX: hx_d = sp_q + 16'h0001;
                    K_HX2S: sp_d = hx_q - 16'h0001;
                    K_ZACC: flg_d = nz(flg_q, a_q);
                    K_ZIDX: flg_d = nz(flg_q, hx_q[7:0]);
                    K_ZMEM: begin
                        mem_req.rd = 1'b1;
                        flg_d = nz(flg_q, mem_rdata);
                    end
                    K_LOAD: begin
                        mem_req.rd = 1'b1;
                        a_d = mem_rdata;
                        flg_d = nz(flg_q, mem_rdata);
                    end
                    K_JUMP: pc_d = pc_q + {{8{rel[7]}}, rel};
                    K_CMPBR: begin
                        mem_req.rd = 1'b1;
                        hx_d = hx_q + 16'h0001;
                        if (a_q == mem_rdata) begin
                            pc_d = pc_q + {{8{rel[7]}}, rel};
                        end
                    end
                    K_BITBR: begin
                        mem_req.rd = 1'b1;
                        flg_d[`CIS_FLG_C] = bitv;
                        if (bitv ^ dec_q.sub[0]) begin
                            pc_d = pc_q + {{8{rel[7]}}, rel};
                        end
                    end
                    K_MOVE: begin
                        st_d = S_WRITE;
                        if (dec_q.mode == M_LIT2SH) begin
                            tmp_d = b1_q;
                        end else begin
                            mem_req.rd = 1'b1;
                            tmp_d = mem_rdata;
                            if (dec_q.mode == M_PI2SH) begin
                                hx_d = hx_q + 16'h0001;
                            end
                        end
                    end
                    K_TRAP: begin
                        st_d = S_PUSH;
                        cnt_d = 3'h0;
                    end
                    K_NOP: st_d = S_FETCH;
                endcase
            end
            S_WRITE: begin
                st_d = S_FETCH;
                mem_req.wr = 1'b1;
                mem_req.wdata = tmp_q;
                flg_d = nz(flg_q, tmp_q);
                if (dec_q.mode == M_SH2PI) begin
                    mem_req.addr = hx_q;
                    hx_d = hx_q + 16'h0001;
                end else if (dec_q.mode == M_PI2SH) begin
                    mem_req.addr = {8'h00, b1_q};
                end else begin
                    mem_req.addr = {8'h00, b2_q};
                end
            end
            S_PUSH: begin
                mem_req.wr = 1'b1;
                mem_req.addr = sp_q;
                sp_d = sp_q - 16'h0001;
                cnt_d = cnt_q + 3'h1;
                unique case (cnt_q)
                    3'h0: mem_req.wdata = pc_q[7:0];
                    3'h1: mem_req.wdata = pc_q[15:8];
                    3'h2: mem_req.wdata = hx_q[7:0];
                    3'h3: mem_req.wdata = a_q;
                    default: mem_req.wdata = flg_q;
                endcase
                if (cnt_q == 3'h4) begin
                    flg_d[`CIS_FLG_I] = 1'b1;
                    st_d = S_VECH;
                end
            end
            S_VECH: begin
                mem_req.rd = 1'b1;
                mem_req.addr = `CIS_VEC_TRAP;
                tmp_d = mem_rdata;
                st_d = S_VECL;
            end
            S_VECL: begin
                mem_req.rd = 1'b1;
                mem_req.addr = `CIS_VEC_TRAP + 16'h0001;
                pc_d = {tmp_q, mem_rdata};
                st_d = S_FETCH;
            end
        endcase
        retire_d = (st_d == S_FETCH) && (st_q != S_FETCH);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= S_FETCH;
            dec_q <= '{K_NOP, M_NONE, 2'h0, 4'h0};
            pc_q <= `CIS_PC_RST;
            hx_q <= 16'h0000;
            sp_q <= `CIS_SP_RST;
            a_q <= 8'h00;
            flg_q <= `CIS_FLG_RST;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            tmp_q <= 8'h00;
            cnt_q <= 3'h0;
            retire_q <= 1'b0;
        end else begin
            st_q <= st_d;
            dec_q <= dec_d;
            pc_q <= pc_d;
            hx_q <= hx_d;
            sp_q <= sp_d;
            a_q <= a_d;
            flg_q <= flg_d;
            b1_q <= b1_d;
            b2_q <= b2_d;
            tmp_q <= tmp_d;
            cnt_q <= cnt_d;
            retire_q <= retire_d;
        end
    end

    assign regs = '{acc: a_q, hx: hx_q, sp: sp_q, pc: pc_q, flg: flg_q};
    assign retire = retire_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    a_zero_test: assert property (
        (st_q == S_EXEC && dec_q.kind == K_ZMEM) |=> (!flg_q[`CIS_FLG_V]
        && flg_q[`CIS_FLG_Z] == ($past(mem_rdata) == 8'h00)
        && flg_q[`CIS_FLG_C] == $past(flg_q[`CIS_FLG_C])))
        else $error("zero test flags wrong");
    a_postinc_plain: assert property (
        (st_q == S_EXEC && dec_q.mode == M_PI) |-> mem_req.addr == hx_q
        ##1 hx_q == $past(hx_q) + 16'h0001)
        else $error("plain post-increment wrong");
    a_postinc_byte: assert property (
        (st_q == S_EXEC && dec_q.mode == M_PI8)
        |-> mem_req.addr == hx_q + {8'h00, b1_q}
        ##1 hx_q == $past(hx_q) + 16'h0001)
        else $error("byte offset post-increment wrong");
    a_short_to_idx: assert property (
        (st_q == S_WRITE && dec_q.mode == M_SH2PI)
        |-> (mem_req.wr && mem_req.addr == hx_q)
        ##1 hx_q == $past(hx_q) + 16'h0001)
        else $error("short to indexed move wrong");
    a_idx_to_short: assert property (
        (st_q == S_WRITE && dec_q.mode == M_PI2SH)
        |-> mem_req.addr == {8'h00, b1_q} && mem_req.wdata == $past(mem_rdata)
        && hx_q == $past(hx_q) + 16'h0001)
        else $error("indexed to short move wrong");
    a_literal_move: assert property (
        (st_q == S_EXEC && dec_q.mode == M_LIT2SH) |=> (mem_req.wr
        && mem_req.wdata == $past(b1_q) && mem_req.addr == {8'h00, b2_q}))
        else $error("literal move wrong");
    a_long_abs: assert property (
        (st_q == S_EXEC && dec_q.mode == M_LONG)
        |-> mem_req.addr == {b1_q, b2_q})
        else $error("long absolute address wrong");
    a_stack_byte: assert property (
        (st_q == S_EXEC && dec_q.mode == M_STK8)
        |-> mem_req.addr == sp_q + {8'h00, b1_q} && $past(st_q, 2) == S_PRE)
        else $error("stack byte offset wrong");
    a_rel_branch: assert property (
        (st_q == S_EXEC && dec_q.kind == K_JUMP) |=> pc_q == $past(pc_q)
        + {{8{$past(b1_q[7])}}, $past(b1_q)})
        else $error("relative branch target wrong");
    a_trap_push: assert property (
        (st_q == S_EXEC && dec_q.kind == K_TRAP) |=> (mem_req.wr
        && mem_req.addr == $past(sp_q) && mem_req.wdata == $past(pc_q[7:0]))
        ##5 (st_q == S_VECH && flg_q[`CIS_FLG_I]))
        else $error("trap sequence wrong");
    a_stack_copy: assert property (
        (st_q == S_EXEC && dec_q.kind == K_S2HX)
        |=> hx_q == $past(sp_q) + 16'h0001 && flg_q == $past(flg_q))
        else $error("stack to pair copy wrong");
    a_flag_load: assert property (
        (st_q == S_EXEC && dec_q.kind == K_FLGLD)
        |=> flg_q == ($past(a_q) | `CIS_FLG_ONES))
        else $error("flag load wrong");
endmodule

// File: src/cis_defs.svh
/*
 Constants of the instruction tail decoder: opcodes, flag bit positions,
 reset values and the trap vector.
 Assumes it is included by the core, nowhere else.
*/
// Behaviour
// - Zero test on accumulator, index low or memory sets N, Z and clears V
// - Plain post-increment: address is the index pair, then pair increments
// - Byte-offset post-increment: pair plus unsigned byte, then increment
// - Short to indexed move: read page zero, write at pair, increment
// - Indexed to short move: read pair, increment, write page zero
// - Literal move: literal byte stored at following page-zero address byte
// - Long absolute: high then low address byte form the 16-bit address
// - Word-offset index: 16-bit offset, high byte first, added to pair
// - Stack byte offset: prefixed opcode, unsigned byte added to stack
// - Stack word offset: 16-bit offset, high byte first, added to stack
// - Bit branch: page-zero operand byte, then signed displacement byte
// - Relative branch: signed byte added to address after the instruction
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH
`define CIS_FLG_V 7
`define CIS_FLG_I 3
`define CIS_FLG_N 2
`define CIS_FLG_Z 1
`define CIS_FLG_C 0
`define CIS_FLG_ONES 8'h60
`define CIS_FLG_RST 8'h68
`define CIS_SP_RST 16'h00FF
`define CIS_PC_RST 16'h0000
`define CIS_VEC_TRAP 16'hFFFC
`define CIS_OP_PREFIX 8'h9E
`define CIS_OP_JUMP 8'h20
`define CIS_OP_ZMEM_SH 8'h3D
`define CIS_OP_ZACC 8'h4D
`define CIS_OP_ZIDX 8'h5D
`define CIS_OP_ZMEM_I8 8'h6D
`define CIS_OP_ZMEM_IX 8'h7D
`define CIS_OP_MV_SH2SH 8'h4E
`define CIS_OP_MV_SH2PI 8'h5E
`define CIS_OP_MV_LIT 8'h6E
`define CIS_OP_MV_PI2SH 8'h7E
`define CIS_OP_CB_PI8 8'h61
`define CIS_OP_CB_PI 8'h71
`define CIS_OP_TRAP 8'h83
`define CIS_OP_FLGLD 8'h84
`define CIS_OP_FLGRD 8'h85
`define CIS_OP_HX2S 8'h94
`define CIS_OP_S2HX 8'h95
`define CIS_OP_A2X 8'h97
`define CIS_OP_X2A 8'h9F
`define CIS_OP_LD_LONG 8'hC6
`define CIS_OP_LD_I16 8'hD6
`define CIS_OP_LD_I8 8'hE6
`define CIS_OP_LD_IX 8'hF6
`define CIS_OP_LD_S8 8'hE6
`define CIS_OP_LD_S16 8'hD6
`endif

// File: src/cis_ea.sv
/*
 Operand address unit: forms the effective address from the operand
 bytes, the index pair and the stack pointer.
 Assumes the operand bytes were fetched in instruction order.
*/
module cis_ea
    import cis_pkg::*;
(
    input wire cis_mode_t mode, // Operand mode
    input wire logic [7:0] b1, // First operand byte
    input wire logic [7:0] b2, // Second operand byte
    input wire logic [15:0] hx, // Index pair
    input wire logic [15:0] sp, // Stack pointer
    output logic [15:0] ea // Effective address
);
    always_comb begin
        unique case (mode)
            M_SHORT, M_SH2SH, M_SH2PI: ea = {8'h00, b1};
            M_LONG: ea = {b1, b2};
            M_IDX16: ea = hx + {b1, b2};
            M_IDX8, M_PI8: ea = hx + {8'h00, b1};
            M_STK8: ea = sp + {8'h00, b1};
            M_STK16: ea = sp + {b1, b2};
            M_IDX, M_PI, M_PI2SH: ea = hx;
            default: ea = {8'h00, b2};
        endcase
    end
endmodule

// File: src/cis_pkg.sv
/*
 Types of the instruction tail decoder: states, kinds, operand modes and
 the structs carried between core, address unit and memory.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package cis_pkg;
    typedef enum {S_FETCH, S_PRE, S_OPND, S_EXEC, S_WRITE, S_PUSH,
                  S_VECH, S_VECL} cis_state_t;
    typedef enum logic [3:0] {K_NOP, K_TRAP, K_FLGLD, K_FLGRD, K_A2X, K_X2A,
                  K_S2HX, K_HX2S, K_ZACC, K_ZIDX, K_ZMEM, K_LOAD, K_MOVE,
                  K_CMPBR, K_BITBR, K_JUMP} cis_kind_t;
    typedef enum logic [3:0] {M_NONE, M_SHORT, M_LONG, M_IDX, M_IDX8,
                  M_IDX16, M_STK8, M_STK16, M_PI, M_PI8, M_SH2SH, M_SH2PI,
                  M_LIT2SH, M_PI2SH} cis_mode_t;
    typedef struct packed {
        cis_kind_t kind;
        cis_mode_t mode;
        logic [1:0] nbytes;
        logic [3:0] sub;
    } cis_dec_t;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cis_mem_req_t;
    typedef struct packed {
        logic [7:0] acc;
        logic [15:0] hx;
        logic [15:0] sp;
        logic [15:0] pc;
        logic [7:0] flg;
    } cis_regs_t;
endpackage

// File: tb/cis_core_tb.sv
/*
 Self-checking bench of the instruction tail core: copies, zero test,
 moves, operand modes, trap and branches, each from a fresh reset.
 Assumes the memory model answers reads combinationally.
*/
module cis_core_tb
    import cis_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CYC_LIMIT = 3000;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] mem_rdata;
    cis_mem_req_t mem_req;
    cis_regs_t regs;
    logic retire;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;

    always #5 mclk = ~mclk;

    cis_core DUT (
        .mclk(mclk),
        .arst_n(arst_n),
        .mem_rdata(mem_rdata),
        .mem_req(mem_req),
        .regs(regs),
        .retire(retire)
    );

    cis_mem_model mem_u (
        .mclk(mclk),
        .mem_req(mem_req),
        .mem_rdata(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            stop_test();
        end
    end

    // Clearing waits for the falling edge so no core write lands on it
    task automatic rst_on();
        @(posedge mclk);
        arst_n <= 1'b0;
        @(negedge mclk);
        for (int i = 0; i < 65536; i++)
            mem_u.mem[i] = 8'h00;
    endtask

    task automatic rst_off();
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
    endtask

    task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
        foreach (b[i])
            mem_u.mem[16'(a + i)] = b[i];
    endtask

    // Waits for n retire pulses; registers are settled at the falling edge
    task automatic run(input int n);
        int w;
        repeat (n) begin
            w = 0;
            @(negedge mclk);
            while (retire !== 1'b1 && w < 40) begin
                @(negedge mclk);
                w++;
            end
            if (w >= 40)
                check(64'h0, 64'h1, "retire");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_copies();
        rst_on();
        check(regs, 64'h00_0000_00FF_0000_68, "reset regs");
        put(16'h0000, '{8'hC6, 8'h10, 8'h00, 8'h97, 8'h94, 8'h85, 8'h97,
                        8'h95, 8'hC6, 8'h10, 8'h01, 8'h84, 8'h9F});
        put(16'h1000, '{8'h5A, 8'h87});
        rst_off();
        run(2);
        check({regs.hx, regs.flg}, 24'h005A68, "acc to x");
        run(1);
        check(regs.sp, 16'h0059, "pair to sp");
        run(1);
        check({regs.acc, regs.flg}, 16'h6868, "flags to acc");
        run(2);
        check({regs.hx, regs.flg}, 24'h005A68, "sp to pair");
        run(2);
        check(regs.flg, 8'hE7, "acc to flags");
        run(1);
        check({regs.acc, regs.flg}, 16'h5AE7, "x to acc");
    endtask

    // Zero tests alternate N and Z so a stale flag shows at once
    task automatic t_zero();
        logic [7:0] exp_f [6] = '{8'h65, 8'h63, 8'h65, 8'h63, 8'h65, 8'h63};
        rst_on();
        put(16'h0000, '{8'hC6, 8'h10, 8'h00, 8'h84, 8'h4D, 8'h3D, 8'h20,
                        8'h7D, 8'h5D, 8'h9E, 8'h6D, 8'h01, 8'h6D, 8'h30});
        put(16'h1000, '{8'h81});
        put(16'h0100, '{8'h80});
        rst_off();
        run(2);
        check(regs.flg, 8'hE1, "flag load");
        foreach (exp_f[i]) begin
            run(1);
            check(regs.flg, exp_f[i], "zero test flags");
        end
    endtask

    task automatic t_move();
        rst_on();
        put(16'h0000, '{8'hC6, 8'h10, 8'h00, 8'h97, 8'h5E, 8'h20, 8'h7E,
                        8'h21, 8'h6E, 8'h5A, 8'h22, 8'h4E, 8'h20, 8'h23});
        put(16'h1000, '{8'h80});
        put(16'h0020, '{8'h11});
        put(16'h0081, '{8'h33});
        rst_off();
        run(3);
        check({mem_u.mem[16'h0080], regs.hx}, 24'h110081, "to pi");
        run(1);
        check({mem_u.mem[16'h0021], regs.hx}, 24'h330082, "to short");
        run(1);
        check(mem_u.mem[16'h0022], 8'h5A, "literal move");
        run(1);
        check(mem_u.mem[16'h0023], 8'h11, "short to short");
    endtask

    task automatic t_loads();
        rst_on();
        put(16'h0000, '{8'hC6, 8'h10, 8'h00, 8'h97, 8'hC6, 8'h12, 8'h34,
                        8'hD6, 8'h01, 8'h00, 8'h9E, 8'hE6, 8'hF0, 8'h9E,
                        8'hD6, 8'h10, 8'h00});
        put(16'h1000, '{8'h20});
        put(16'h1234, '{8'hA1});
        put(16'h0120, '{8'hA2});
        put(16'h01EF, '{8'hA3});
        put(16'h10FF, '{8'hA4});
        rst_off();
        run(3);
        check(regs.acc, 8'hA1, "long absolute");
        run(1);
        check(regs.acc, 8'hA2, "word offset index");
        run(1);
        check(regs.acc, 8'hA3, "stack byte offset");
        run(1);
        check(regs.acc, 8'hA4, "stack word offset");
    endtask

    task automatic t_trap();
        rst_on();
        put(16'h0000, '{8'hC6, 8'h10, 8'h00, 8'h97, 8'h84, 8'h83});
        put(16'h1000, '{8'h31});
        put(16'hFFFC, '{8'h12, 8'h34});
        rst_off();
        run(4);
        check({regs.pc, regs.sp, regs.flg}, 40'h123400FA79, "trap");
        check({mem_u.mem[16'h00FF], mem_u.mem[16'h00FE], mem_u.mem[16'h00FD],
               mem_u.mem[16'h00FC], mem_u.mem[16'h00FB]},
              40'h0600313171, "trap stack");
    endtask

    task automatic t_branch();
        rst_on();
        put(16'h0000, '{8'h20, 8'h20});
        put(16'h0004, '{8'h00, 8'h30, 8'h08});
        put(16'h000F, '{8'h01, 8'h30, 8'hF0, 8'h71, 8'h05, 8'h61, 8'h40,
                        8'h04});
        put(16'h0022, '{8'h20, 8'hE0});
        put(16'h0030, '{8'h01});
        rst_off();
        run(1);
        check(regs.pc, 16'h0022, "branch forward");
        run(1);
        check(regs.pc, 16'h0004, "branch back");
        run(1);
        check(regs.pc, 16'h000F, "bit set taken");
        run(1);
        check(regs.pc, 16'h0012, "bit clear not taken");
        run(1);
        check({regs.pc, regs.hx}, 32'h00140001, "pi compare");
        run(1);
        check({regs.pc, regs.hx}, 32'h001B0002, "pi8 compare");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_copies();
        t_zero();
        t_move();
        t_loads();
        t_trap();
        t_branch();
        stop_test();
    end
endmodule

// File: tb/cis_mem_model.sv
/*
 Program and data memory seen by the core: 64 KiB, read answered in the
 same cycle, write taken at the clock edge.
 Assumes the bench preloads and clears the array while the core is reset.
*/
module cis_mem_model
    import cis_pkg::*;
(
    input wire logic mclk, // Core clock
    input wire cis_mem_req_t mem_req, // Access from the core
    output logic [7:0] mem_rdata // Read data, same cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'hA5;

    ////////////////////////////////////////////////////////////////////////
    // Plain always: the bench also writes the array while loading programs
    always @(posedge mclk) begin
        if (mem_req.wr)
            mem[mem_req.addr] <= mem_req.wdata;
        if (mem_req.rd)
            last_q <= mem[mem_req.addr];
    end

    // Released bus shows the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;
endmodule
